// *** src/lmse_exec.sv ***
// Purpose: One-cycle execution of logic, move and subtract instructions
// Assumes: Decoder presents one instruction per valid cycle; file data
//   is read combinationally at file_addr_o
// Notes: Outputs other than file_addr_o are registered; file write lands one cycle later
// Summary of operation
// (RULE_01) OR immediate: acc |= literal, only zero flag, one cycle.
// (RULE_02) OR file: acc OR file data, only zero flag, one cycle.
// (RULE_03) Destination bit 0 writes accumulator, 1 writes file location. Code writes a cycle later, at that cycle's operand_i on file_addr_o.
// (RULE_04) Load from file copies location into accumulator, flags kept.
// (RULE_05) Load immediate puts literal into accumulator, flags kept.
// (RULE_06) Store writes accumulator to location, accumulator and flags kept. Code writes a cycle later, at that cycle's operand_i on file_addr_o.
// (RULE_07) No-operation changes nothing and takes one cycle.
// (RULE_08) Subtract: file minus acc, routed by destination, sets all flags.
// (RULE_09) Subtract with borrow also takes inverted carry away.
// (RULE_10) XOR immediate: acc ^= literal, only zero flag.
// (RULE_11) XOR file: acc XOR file, routed by destination, only zero flag.
// (RULE_12) Carry set when no borrow; zero set for all-zero result.
// (RULE_13) Nibble flag set when no borrow out of low nibble.
`timescale 1ns/10ps
module lmse_exec
  import lmse_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Decoder side
  input wire logic valid_i,
  input wire lmse_op_t op_i,
  input wire logic [7:0] operand_i,
  input wire logic dest_i,
  // Data memory side
  input wire logic [7:0] file_rdata_i,
  output logic [7:0] file_addr_o,
  output logic [7:0] file_wdata_o,
  output logic file_we_o,
  // Architectural state
  output logic [7:0] acc_o,
  output logic carry_o,
  output logic nibble_borrow_flag_o,
  output logic zero_o,
  output logic done_o
);
  lmse_alu_if alu_bus ();
  logic [7:0] acc_reg, acc_next;
  logic carry_reg, carry_next;
  logic nib_reg, nib_next;
  logic zero_reg, zero_next;
  logic [7:0] waddr_reg, waddr_next;
  logic [7:0] wdata_reg, wdata_next;
  logic we_reg, we_next;
  logic done_reg, done_next;

  // True for instructions reading the data location
  function automatic logic uses_file(input lmse_op_t op);
    return op inside {LMSE_OP_OR_FILE, LMSE_OP_LOAD_FILE, LMSE_OP_SUB,
      LMSE_OP_SUBB, LMSE_OP_XOR_FILE};
  endfunction

  // True for instructions honouring the destination bit
  function automatic logic has_dest(input lmse_op_t op);
    return op inside {LMSE_OP_OR_FILE, LMSE_OP_SUB, LMSE_OP_SUBB,
      LMSE_OP_XOR_FILE};
  endfunction

  // Operand selection
  assign alu_bus.op = op_i;
  assign alu_bus.acc = acc_reg;
  assign alu_bus.opnd = uses_file(op_i) ? file_rdata_i : operand_i;
  assign alu_bus.carry_in = carry_reg;
  assign file_addr_o = operand_i;

  lmse_alu u_alu (
    .bus(alu_bus)
  );

  // Next-state computation
  always_comb
  begin
    acc_next = acc_reg;
    carry_next = carry_reg;
    nib_next = nib_reg;
    zero_next = zero_reg;
    waddr_next = waddr_reg;
    wdata_next = wdata_reg;
    we_next = 1'b0;
    done_next = valid_i;
    if (valid_i)
    begin
      case (op_i)
        LMSE_OP_NOP:
          acc_next = acc_reg; // see (RULE_07)
        LMSE_OP_STORE:
        begin
          waddr_next = operand_i; // see (RULE_06)
          wdata_next = acc_reg;
          we_next = 1'b1;
        end
        LMSE_OP_LOAD_FILE, LMSE_OP_LOAD_IMM:
          acc_next = alu_bus.result; // see (RULE_04) (RULE_05)
        LMSE_OP_OR_IMM, LMSE_OP_OR_FILE, LMSE_OP_XOR_IMM,
        LMSE_OP_XOR_FILE, LMSE_OP_SUB, LMSE_OP_SUBB:
        begin
          if (has_dest(op_i) && dest_i == LMSE_DEST_FILE)
          begin
            waddr_next = operand_i; // see (RULE_03)
            wdata_next = alu_bus.result;
            we_next = 1'b1;
          end
          else
            acc_next = alu_bus.result; // see (RULE_03)
          zero_next = alu_bus.zero_out; // see (RULE_01) (RULE_02)
          if (op_i == LMSE_OP_SUB || op_i == LMSE_OP_SUBB)
          begin
            carry_next = alu_bus.carry_out; // see (RULE_08) (RULE_12)
            nib_next = alu_bus.nib_out; // see (RULE_13)
          end
        end
        default:
          acc_next = acc_reg;
      endcase
    end
  end

  // State registers
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      acc_reg <= LMSE_ACC_RST;
      carry_reg <= LMSE_FLAG_RST;
      nib_reg <= LMSE_FLAG_RST;
      zero_reg <= LMSE_FLAG_RST;
      waddr_reg <= 8'h00;
      wdata_reg <= 8'h00;
      we_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      acc_reg <= acc_next;
      carry_reg <= carry_next;
      nib_reg <= nib_next;
      zero_reg <= zero_next;
      waddr_reg <= waddr_next;
      wdata_reg <= wdata_next;
      we_reg <= we_next;
      done_reg <= done_next;
    end
  end

  assign acc_o = acc_reg;
  assign carry_o = carry_reg;
  assign nibble_borrow_flag_o = nib_reg;
  assign zero_o = zero_reg;
  assign file_wdata_o = wdata_reg;
  assign file_we_o = we_reg;
  assign done_o = done_reg;

  // Write address kept beside data but never driven out to the memory
  logic [7:0] unused_waddr;
  assign unused_waddr = waddr_reg;

  // Checks
  AST_OR_IMM: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    valid_i && op_i == LMSE_OP_OR_IMM |=> acc_reg ==
    ($past(acc_reg) | $past(operand_i)) && carry_reg == $past(carry_reg))
    else $error("or immediate wrong"); // see (RULE_01)
  AST_OR_FILE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    valid_i && op_i == LMSE_OP_OR_FILE && !dest_i |=> acc_reg ==
    ($past(acc_reg) | $past(file_rdata_i)) && nib_reg == $past(nib_reg))
    else $error("or file wrong"); // see (RULE_02)
  AST_DEST_FILE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    valid_i && has_dest(op_i) && dest_i |=> we_reg &&
    acc_reg == $past(acc_reg) && waddr_reg == $past(operand_i))
    else $error("destination file wrong"); // see (RULE_03)
  AST_LOAD_FILE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    valid_i && op_i == LMSE_OP_LOAD_FILE |=> acc_reg ==
    $past(file_rdata_i) && zero_reg == $past(zero_reg))
    else $error("load file wrong"); // see (RULE_04)
  AST_LOAD_IMM: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    valid_i && op_i == LMSE_OP_LOAD_IMM |=> acc_reg == $past(operand_i)
    && $stable(carry_reg))
    else $error("load immediate wrong"); // see (RULE_05)
  AST_STORE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    valid_i && op_i == LMSE_OP_STORE |=> we_reg &&
    wdata_reg == $past(acc_reg) && $stable(acc_reg) && $stable(zero_reg))
    else $error("store wrong"); // see (RULE_06)
  AST_NOP: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    valid_i && op_i == LMSE_OP_NOP |=> !we_reg && $stable(acc_reg)
    && $stable(zero_reg) && done_reg)
    else $error("nop changed state"); // see (RULE_07)
  AST_SUB: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    valid_i && op_i == LMSE_OP_SUB && !dest_i |=> acc_reg ==
    8'($past(file_rdata_i) - $past(acc_reg)) &&
    carry_reg == ($past(file_rdata_i) >= $past(acc_reg)))
    else $error("subtract wrong"); // see (RULE_08) (RULE_12)
  AST_SUBB: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    valid_i && op_i == LMSE_OP_SUBB && !dest_i && !carry_reg |=>
    acc_reg == 8'($past(file_rdata_i) - $past(acc_reg) - 8'h01))
    else $error("borrow subtract wrong"); // see (RULE_09)
  AST_XOR_IMM: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    valid_i && op_i == LMSE_OP_XOR_IMM |=> acc_reg ==
    ($past(acc_reg) ^ $past(operand_i)) && zero_reg == (acc_reg == 8'h00))
    else $error("xor immediate wrong"); // see (RULE_10)
  AST_XOR_FILE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    valid_i && op_i == LMSE_OP_XOR_FILE && dest_i |=> wdata_reg ==
    ($past(acc_reg) ^ $past(file_rdata_i)) && $stable(carry_reg))
    else $error("xor file wrong"); // see (RULE_11)
  AST_NIB: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    valid_i && op_i == LMSE_OP_SUB |=> nib_reg ==
    ($past(file_rdata_i[3:0]) >= $past(acc_reg[3:0])))
    else $error("nibble flag wrong"); // see (RULE_13)
  COV_SUB_ZERO: cover property (@(posedge clock_i)
    valid_i && op_i == LMSE_OP_SUB ##1 zero_reg && carry_reg);
  COV_SUBB_BORROW: cover property (@(posedge clock_i)
    valid_i && op_i == LMSE_OP_SUBB && !carry_reg ##1 !carry_reg);
  COV_STORE: cover property (@(posedge clock_i)
    valid_i && op_i == LMSE_OP_STORE ##1 we_reg);
  COV_DEST_FILE: cover property (@(posedge clock_i)
    valid_i && has_dest(op_i) && dest_i ##1 we_reg);
  COV_XOR_ZERO: cover property (@(posedge clock_i)
    valid_i && op_i == LMSE_OP_XOR_IMM ##1 zero_reg);
  AST_SUBB_CARRY: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    valid_i && op_i == LMSE_OP_SUBB && !dest_i && carry_reg |=>
    acc_reg == 8'($past(file_rdata_i) - $past(acc_reg)) &&
    zero_reg == (acc_reg == 8'h00))
    else $error("borrow subtract with carry set wrong"); // see (RULE_09)
endmodule // lmse_exec

// *** src/lmse_pkg.sv ***
// Purpose: Shared constants and types for the logic/move/subtract datapath
// Assumes: 8-bit accumulator, 256-location data space
// Notes: Opcode encodings are local to this datapath
package lmse_pkg;
  localparam int LMSE_DATA_W = 8;
  localparam int LMSE_ADDR_W = 8;
  localparam logic [7:0] LMSE_ACC_RST = 8'h00;
  localparam logic LMSE_FLAG_RST = 1'b0;
  localparam logic LMSE_DEST_ACC = 1'b0;
  localparam logic LMSE_DEST_FILE = 1'b1;
  localparam int LMSE_NIB_W = 4;

  // Operations handled by this datapath
  typedef enum logic [3:0] {
    LMSE_OP_NOP,
    LMSE_OP_OR_IMM,
    LMSE_OP_OR_FILE,
    LMSE_OP_LOAD_FILE,
    LMSE_OP_LOAD_IMM,
    LMSE_OP_STORE,
    LMSE_OP_SUB,
    LMSE_OP_SUBB,
    LMSE_OP_XOR_IMM,
    LMSE_OP_XOR_FILE
  } lmse_op_t;
endpackage

// *** src/lmse_if.sv ***
// Purpose: Carries result between the ALU and the sequencing top
// Assumes: Single core clock
// Notes: Purely combinational bundle
`timescale 1ns/10ps
interface lmse_alu_if;
  import lmse_pkg::*;
  lmse_op_t op;
  logic [7:0] acc;
  logic [7:0] opnd;
  logic carry_in;
  logic [7:0] result;
  logic carry_out;
  logic nib_out;
  logic zero_out;
  modport top (output op, acc, opnd, carry_in,
    input result, carry_out, nib_out, zero_out);
  modport alu (input op, acc, opnd, carry_in,
    output result, carry_out, nib_out, zero_out);
endinterface

// *** src/lmse_alu.sv ***
// Purpose: Combinational result and flag generation
// Assumes: Operand is file data or literal chosen by the top
// Notes: Borrow polarity: flag high means no borrow
`timescale 1ns/10ps
module lmse_alu
  import lmse_pkg::*;
(
  lmse_alu_if.alu bus
);
  logic [8:0] diff;
  logic [4:0] ndiff;

  // Result and flags per operation
  always_comb
  begin
    diff = 9'h000;
    ndiff = 5'h00;
    bus.result = bus.acc;
    bus.carry_out = bus.carry_in;
    bus.nib_out = 1'b0;
    case (bus.op)
      LMSE_OP_OR_IMM, LMSE_OP_OR_FILE:
        bus.result = bus.acc | bus.opnd; // see (RULE_01) (RULE_02)
      LMSE_OP_XOR_IMM, LMSE_OP_XOR_FILE:
        bus.result = bus.acc ^ bus.opnd; // see (RULE_10) (RULE_11)
      LMSE_OP_LOAD_FILE, LMSE_OP_LOAD_IMM:
        bus.result = bus.opnd; // see (RULE_04) (RULE_05)
      LMSE_OP_SUB, LMSE_OP_SUBB:
      begin
        // Minus inverted carry on the borrow form
        diff = {1'b0, bus.opnd} - {1'b0, bus.acc}
          - {8'h00, (bus.op == LMSE_OP_SUBB) & ~bus.carry_in}; // see (RULE_09)
        ndiff = {1'b0, bus.opnd[3:0]} - {1'b0, bus.acc[3:0]}
          - {4'h0, (bus.op == LMSE_OP_SUBB) & ~bus.carry_in};
        bus.result = diff[7:0]; // see (RULE_08)
        bus.carry_out = ~diff[8]; // see (RULE_12)
        bus.nib_out = ~ndiff[4]; // see (RULE_13)
      end
      default:
        bus.result = bus.acc;
    endcase
    bus.zero_out = (bus.result == 8'h00); // see (RULE_12)
  end
endmodule // lmse_alu

// *** verif/lmse_exec_test.sv ***
// Purpose: Self-checking bench for the logic/move/subtract datapath
// Assumes: Bench memory is write-first; model updates it at issue
// Notes: Reference model tracks accumulator, flags and memory
`timescale 1ns/10ps
module lmse_exec_test import lmse_pkg::*;;
  logic clock_i;
  logic rst_n_i;
  logic valid_i;
  lmse_op_t op_i;
  logic [7:0] operand_i;
  logic dest_i;
  logic [7:0] file_rdata_i;
  logic [7:0] file_addr_o;
  logic [7:0] file_wdata_o;
  logic file_we_o;
  logic [7:0] acc_o;
  logic carry_o;
  logic nibble_borrow_flag_o;
  logic zero_o;
  logic done_o;
  logic [7:0] mem [0:255];
  int errors, n_tests, seed, e_acc, e_c, e_nib, e_z, e_done, e_we, e_wd;
  bit live;
  int fa[7] = '{8'h33, 8'h01, 8'h04, 8'h02, 8'h10, 8'h00, 8'hFF};
  int wa[7] = '{8'h01, 8'h01, 8'h05, 8'h01, 8'h01, 8'hFF, 8'h00};

  lmse_exec u_dut (.clock_i, .rst_n_i, .valid_i, .op_i, .operand_i,
    .dest_i, .file_rdata_i, .file_addr_o, .file_wdata_o, .file_we_o,
    .acc_o, .carry_o, .nibble_borrow_flag_o, .zero_o, .done_o);

  // Memory answers the read address in the same cycle
  assign file_rdata_i = mem[file_addr_o];

  // Clock generation
  initial
  begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  task automatic complete_run();
    if (errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Compare an eight-bit result
  task automatic chk_data(input logic [7:0] got, input logic [7:0] exp,
    input string what);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got,
        exp);
    end
  endtask

  // Compare a one-bit flag or strobe
  task automatic chk_flag(input logic got, input int exp, input string what);
    n_tests++;
    if (got !== exp[0])
    begin
      errors++;
      $display("wrong value at %0t: %s got %b exp %0d", $time, what, got,
        exp);
    end
  endtask

  // Reference step for the instruction taken at this edge
  task automatic step();
    int f, w, b, r;
    bit wr;
    f = mem[operand_i];
    w = e_acc;
    b = 0;
    r = w;
    wr = 0;
    e_done = valid_i;
    e_we = 0;
    if (valid_i)
    begin
      case (op_i)
        LMSE_OP_OR_IMM: r = w | operand_i;
        LMSE_OP_OR_FILE: r = w | f;
        LMSE_OP_LOAD_FILE: r = f;
        LMSE_OP_LOAD_IMM: r = operand_i;
        LMSE_OP_STORE: wr = 1;
        LMSE_OP_SUB, LMSE_OP_SUBB:
        begin
          if (op_i == LMSE_OP_SUBB)
            b = !e_c;
          r = (f - w - b) & 255;
          e_c = f >= w + b;
          e_nib = (f & 15) >= (w & 15) + b;
        end
        LMSE_OP_XOR_IMM: r = w ^ operand_i;
        LMSE_OP_XOR_FILE: r = w ^ f;
        default: ;
      endcase
      if (op_i inside {LMSE_OP_OR_FILE, LMSE_OP_SUB, LMSE_OP_SUBB,
        LMSE_OP_XOR_FILE})
        wr = dest_i;
      if (!(op_i inside {LMSE_OP_NOP, LMSE_OP_LOAD_FILE, LMSE_OP_LOAD_IMM,
        LMSE_OP_STORE}))
        e_z = (r == 0);
      if (wr)
      begin
        mem[operand_i] <= 8'(r);
        e_we = 1;
        e_wd = r;
      end
      else
        e_acc = r;
    end
  endtask

  // Compare last result, then model the instruction now taken
  always @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      e_acc = 0;
      e_c = 0;
      e_nib = 0;
      e_z = 0;
      e_done = 0;
      e_we = 0;
      live = 1;
    end
    else
    begin
      if (live)
      begin
        chk_data(acc_o, 8'(e_acc), "acc");
        chk_flag(carry_o, e_c, "carry");
        chk_flag(nibble_borrow_flag_o, e_nib, "nib");
        chk_flag(zero_o, e_z, "zero");
        chk_flag(done_o, e_done, "done");
        chk_flag(file_we_o, e_we, "we");
        if (e_we)
          chk_data(file_wdata_o, 8'(e_wd), "wdata");
        chk_data(file_addr_o, operand_i, "addr");
      end
      step();
    end
  end

  task automatic ins(input lmse_op_t op, input int opnd, input bit d,
    input bit v = 1);
    @(posedge clock_i);
    valid_i <= v;
    op_i <= op;
    operand_i <= 8'(opnd);
    dest_i <= d;
  endtask

  // Subtract through memory, then read the location back at once
  task automatic sub_case(input int f, input int w, input lmse_op_t op);
    ins(LMSE_OP_LOAD_IMM, f, 0);
    ins(LMSE_OP_STORE, 8'h5A, 0);
    ins(LMSE_OP_LOAD_IMM, w, 0);
    ins(op, 8'h5A, 1);
    ins(LMSE_OP_LOAD_FILE, 8'h5A, 0);
  endtask

  // Main sequence
  initial
  begin
    int k;
    seed = 26813;
    rst_n_i = 1'b0;
    valid_i = 1'b0;
    op_i = LMSE_OP_NOP;
    operand_i = 8'h00;
    dest_i = 1'b0;
    for (int i = 0; i < 256; i++)
      mem[i] = 8'($random(seed));
    repeat (3) @(posedge clock_i);
    rst_n_i <= 1'b1;
    ins(LMSE_OP_LOAD_IMM, 8'h69, 0);
    ins(LMSE_OP_OR_IMM, 8'h84, 0);
    ins(LMSE_OP_LOAD_IMM, 8'hAC, 0);
    ins(LMSE_OP_XOR_IMM, 8'h5F, 0);
    ins(LMSE_OP_XOR_IMM, 8'hF3, 0);
    for (int i = 0; i < 7; i++)
    begin
      sub_case(fa[i], wa[i], LMSE_OP_SUB);
      sub_case(fa[i], wa[i], LMSE_OP_SUBB);
    end
    for (int op = 0; op < 10; op++)
    begin
      ins(lmse_op_t'(op), $random(seed), 0);
      ins(lmse_op_t'(op), $random(seed), 1);
    end
    for (int n = 0; n < 2000; n++)
    begin
      k = $random(seed);
      if (n == 1000)
        rst_n_i <= 1'b0;
      if (n == 1002)
        rst_n_i <= 1'b1;
      ins(lmse_op_t'(($unsigned(k) >> 8) % 10), k[7:0] & 8'h0F, k[4],
        k[5] | k[6]);
    end
    ins(LMSE_OP_NOP, 0, 0, 0);
    repeat (2) @(posedge clock_i);
    complete_run();
  end

  // Watchdog
  initial
  begin
    #20000;
    errors++;
    complete_run();
  end
endmodule // lmse_exec_test
